// ===== logic/fprc_top.sv
// fan drive rate, temperature span and remote 1 ramp configuration
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
`include "fprc_cfg.svh"
// Notes on behaviour
// RL1 - three-bit code picks 11.0 to 88.2 Hz
// RL2 - rate code ignored in high-frequency drive
// RL3 - bit 3 chooses high or low drive
// RL4 - bits 7:4 give temperature span code
// RL5 - three span registers at 0x5f..0x61
// RL6 - span registers reset to 0xc4
// RL7 - lock makes registers read-only
// RL8 - ramp register resets to zero
// RL9 - remote 1 channels ramp, not step
// RL10 - ramp codes give 1 to 48 per slot
// RL11 - behaviour 000 remote 1, 111 manual
// RL12 - slow bit divides ramp by four
// RL13 - step at most increment per slot
module fprc_top #(
    parameter int unsigned LF_UNIT_CYC = `FPRC_LF_UNIT_NS / `FPRC_CLK_NS,
    parameter int unsigned SLOT0_CYC   = `FPRC_SLOT0_US * `FPRC_NS_PER_US / `FPRC_CLK_NS,
    parameter int unsigned SLOT1_CYC   = `FPRC_SLOT1_US * `FPRC_NS_PER_US / `FPRC_CLK_NS
) (
    input  wire logic        ref_clk,          // system clock, 100 MHz
    input  wire logic        rst,              // synchronous reset, active high
    input  wire logic [7:0]  reg_addr,         // register address
    input  wire logic [7:0]  reg_wdata,        // register write data
    input  wire logic        reg_wr,           // write strobe
    input  wire logic        reg_rd,           // read strobe
    output logic      [7:0]  reg_rdata,        // read data, cycle after strobe
    input  wire logic [23:0] duty_target,      // computed duty per channel
    output logic      [23:0] duty_now,         // ramped duty per channel
    output logic      [2:0]  drive_type_flag,  // 1 = high-frequency drive
    output logic      [2:0]  lf_period_start,  // low-rate period start pulse
    output logic      [11:0] temp_span,        // span code per channel
    output logic             lock_state        // registers locked
);
    fprc_ramp_if rif ();

    fprc_pkg::fprc_byte_t [2:0] span_r;
    fprc_pkg::fprc_byte_t [2:0] span_nxt;
    fprc_pkg::fprc_byte_t       ramp_r;
    fprc_pkg::fprc_byte_t       ramp_nxt;
    fprc_pkg::fprc_byte_t       cfg6_r;
    fprc_pkg::fprc_byte_t       cfg6_nxt;
    logic [2:0][2:0]            bhv_r;
    logic [2:0][2:0]            bhv_nxt;
    logic                       lock_r;
    logic                       lock_nxt;
    logic [7:0]                 rdata_r;
    logic [7:0]                 rdata_nxt;
    logic                       wr_open;

    // register writes; lock is set-only until reset
    always_comb begin
        span_nxt = span_r;
        ramp_nxt = ramp_r;
        cfg6_nxt = cfg6_r;
        bhv_nxt  = bhv_r;
        lock_nxt = lock_r;
        // RL7 locked writes dropped
        wr_open  = reg_wr && !lock_r;
        if (wr_open) begin
            case (reg_addr)
                // RL5 span register decode
                `FPRC_OFS_SPAN1: span_nxt[0] = reg_wdata;
                `FPRC_OFS_SPAN2: span_nxt[1] = reg_wdata;
                `FPRC_OFS_SPAN3: span_nxt[2] = reg_wdata;
                `FPRC_OFS_RAMP1: ramp_nxt    = reg_wdata;
                `FPRC_OFS_CFG6:  cfg6_nxt    = reg_wdata;
                `FPRC_OFS_BHV1:  bhv_nxt[0]  = reg_wdata[`FPRC_BHV_MSB:`FPRC_BHV_LSB];
                `FPRC_OFS_BHV2:  bhv_nxt[1]  = reg_wdata[`FPRC_BHV_MSB:`FPRC_BHV_LSB];
                `FPRC_OFS_BHV3:  bhv_nxt[2]  = reg_wdata[`FPRC_BHV_MSB:`FPRC_BHV_LSB];
                `FPRC_OFS_CFG1:  lock_nxt    = reg_wdata[`FPRC_LOCK_BIT];
                default: ;
            endcase
        end
    end

    // read mux; unmapped addresses and idle cycles read zero
    always_comb begin
        rdata_nxt = `FPRC_RD_IDLE;
        if (reg_rd) begin
            case (reg_addr)
                `FPRC_OFS_SPAN1: rdata_nxt = span_r[0];
                `FPRC_OFS_SPAN2: rdata_nxt = span_r[1];
                `FPRC_OFS_SPAN3: rdata_nxt = span_r[2];
                `FPRC_OFS_RAMP1: rdata_nxt = ramp_r;
                `FPRC_OFS_CFG6:  rdata_nxt = cfg6_r;
                `FPRC_OFS_BHV1:  rdata_nxt = {bhv_r[0], 5'h00};
                `FPRC_OFS_BHV2:  rdata_nxt = {bhv_r[1], 5'h00};
                `FPRC_OFS_BHV3:  rdata_nxt = {bhv_r[2], 5'h00};
                `FPRC_OFS_CFG1:  rdata_nxt = {7'h00, lock_r};
                default:         rdata_nxt = `FPRC_RD_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            // RL6 span reset value
            span_r  <= {3{`FPRC_RST_SPAN}};
            // RL8 ramp reset value
            ramp_r  <= `FPRC_RST_RAMP;
            cfg6_r  <= `FPRC_RST_CFG6;
            bhv_r   <= {3{`FPRC_RST_BHV}};
            lock_r  <= 1'b0;
            rdata_r <= `FPRC_RD_IDLE;
        end else begin
            span_r  <= span_nxt;
            ramp_r  <= ramp_nxt;
            cfg6_r  <= cfg6_nxt;
            bhv_r   <= bhv_nxt;
            lock_r  <= lock_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // low-rate timebase: one unit is half a period at 88.2 Hz
    logic [22:0]      unit_cnt_r;
    logic [22:0]      unit_cnt_nxt;
    logic             unit_tick;
    logic [2:0][4:0]  per_cnt_r;
    logic [2:0][4:0]  per_cnt_nxt;
    logic [2:0]       start_r;
    logic [2:0]       start_nxt;
    logic [2:0][4:0]  per_len;

    always_comb begin
        unit_tick    = (unit_cnt_r == 23'(LF_UNIT_CYC - 1));
        unit_cnt_nxt = unit_tick ? 23'h000000 : unit_cnt_r + 23'h000001;
        per_cnt_nxt  = per_cnt_r;
        start_nxt    = 3'h0;
        for (int i = 0; i < 3; i++) begin
            // RL1 rate code to period
            per_len[i] = fprc_pkg::fprc_lf_units(span_r[i][`FPRC_LOW_RATE_SELECT_MSB:`FPRC_LOW_RATE_SELECT_LSB]);
            // a new rate code restarts the period, so the count never overruns it
            // RL2 rate ignored in high-frequency drive
            // RL3 drive type bit
            if (span_r[i][`FPRC_HF_BIT] ||
                (span_nxt[i][`FPRC_LOW_RATE_SELECT_MSB:`FPRC_LOW_RATE_SELECT_LSB] !=
                 span_r[i][`FPRC_LOW_RATE_SELECT_MSB:`FPRC_LOW_RATE_SELECT_LSB])) begin
                per_cnt_nxt[i] = 5'h00;
            end else if (unit_tick) begin
                if (per_cnt_r[i] + 5'h01 >= per_len[i]) begin
                    per_cnt_nxt[i] = 5'h00;
                    start_nxt[i]   = 1'b1;
                end else begin
                    per_cnt_nxt[i] = per_cnt_r[i] + 5'h01;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            unit_cnt_r <= 23'h000000;
            per_cnt_r  <= '0;
            start_r    <= 3'h0;
        end else begin
            unit_cnt_r <= unit_cnt_nxt;
            per_cnt_r  <= per_cnt_nxt;
            start_r    <= start_nxt;
        end
    end

    // ramp time slot; table select picks the slot length
    logic [24:0] slot_cnt_r;
    logic [24:0] slot_cnt_nxt;
    logic [24:0] slot_last;
    logic        slot_tick;

    always_comb begin
        // RL10 slot length per table
        slot_last    = cfg6_r[`FPRC_TBL_BIT] ? 25'(SLOT1_CYC - 1) : 25'(SLOT0_CYC - 1);
        slot_tick    = (slot_cnt_r >= slot_last);
        slot_cnt_nxt = slot_tick ? 25'h0000000 : slot_cnt_r + 25'h0000001;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            slot_cnt_r <= 25'h0000000;
        end else begin
            slot_cnt_r <= slot_cnt_nxt;
        end
    end

    always_comb begin
        rif.slot_tick = slot_tick;
        // RL10 increment per slot
        rif.inc       = fprc_pkg::fprc_ramp_inc(ramp_r[`FPRC_RAMP_MSB:`FPRC_RAMP_LSB]);
        rif.slow      = cfg6_r[`FPRC_SLOW_MSB:`FPRC_SLOW_LSB];
        rif.target    = duty_target;
        for (int i = 0; i < 3; i++) begin
            // RL11 remote 1 behaviour enables ramp
            // RL9 ramp only for remote 1 channels
            rif.ramp_en[i] = (bhv_r[i] == fprc_pkg::FPRC_BHV_REMOTE1);
        end
    end

    fprc_ramp u_ramp (
        .ref_clk (ref_clk),
        .rst     (rst),
        .rif     (rif)
    );

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            drive_type_flag[i] = span_r[i][`FPRC_HF_BIT];
            // RL4 span code out
            temp_span[4*i +: 4] = span_r[i][`FPRC_SPAN_MSB:`FPRC_SPAN_LSB];
        end
    end

    assign reg_rdata       = rdata_r;
    assign duty_now        = rif.duty;
    assign lf_period_start = start_r;
    assign lock_state      = lock_r;

    lock_hold_a: assert property (@(posedge ref_clk) disable iff (rst) // RL7
        lock_r |=> $stable(span_r) && $stable(ramp_r) && lock_r)
        else $error("locked register changed");

    span_write_a: assert property (@(posedge ref_clk) disable iff (rst) // RL5
        (reg_wr && !lock_r && reg_addr == `FPRC_OFS_SPAN2)
        |=> span_r[1] == $past(reg_wdata))
        else $error("local span register did not take write");

    span_reset_a: assert property (@(posedge ref_clk) // RL6
        $past(rst) |-> span_r[2] == `FPRC_RST_SPAN && temp_span[11:8] == 4'hc)
        else $error("span register reset value wrong");

    ramp_reset_a: assert property (@(posedge ref_clk) // RL8
        $past(rst) |-> ramp_r == `FPRC_RST_RAMP)
        else $error("ramp register reset value wrong");

    hf_quiet_a: assert property (@(posedge ref_clk) disable iff (rst) // RL2
        drive_type_flag[0] && $past(drive_type_flag[0]) |-> !lf_period_start[0])
        else $error("low-rate pulse in high-frequency drive");

    drive_flag_a: assert property (@(posedge ref_clk) disable iff (rst) // RL3
        (reg_wr && !lock_r && reg_addr == `FPRC_OFS_SPAN1)
        |=> drive_type_flag[0] == $past(reg_wdata[`FPRC_HF_BIT]))
        else $error("drive type flag does not follow bit 3");

    slow_rate_a: assert property (@(posedge ref_clk) disable iff (rst) // RL1
        (unit_tick && start_nxt[0]) |-> per_cnt_r[0] == per_len[0] - 5'h01)
        else $error("low-rate period length wrong");

    read_back_a: assert property (@(posedge ref_clk) disable iff (rst) // RL4
        (reg_rd && reg_addr == `FPRC_OFS_SPAN1)
        |=> reg_rdata[7:4] == $past(temp_span[3:0]))
        else $error("span read back differs from span output");

    inc_table_a: assert property (@(posedge ref_clk) disable iff (rst) // RL10
        ramp_r[2:0] == 3'h7 |-> rif.inc == 6'h30)
        else $error("fastest ramp increment wrong");

    hf_quiet_three_a: assert property (@(posedge ref_clk) disable iff (rst) // RL2
        drive_type_flag[2] && $past(drive_type_flag[2]) |-> !lf_period_start[2])
        else $error("low-rate pulse on channel three in high-frequency drive");

    hf_clear_a: assert property (@(posedge ref_clk) disable iff (rst) // RL2
        drive_type_flag[0] |=> per_cnt_r[0] == 5'h00)
        else $error("period counter runs in high-frequency drive");

    per_bound_a: assert property (@(posedge ref_clk) disable iff (rst) // RL1
        per_cnt_r[0] < per_len[0])
        else $error("period count beyond its length");

    start_pulse_a: assert property (@(posedge ref_clk) disable iff (rst) // RL1
        lf_period_start[0] |=> !lf_period_start[0])
        else $error("period start pulse longer than one cycle");

    unit_wrap_a: assert property (@(posedge ref_clk) disable iff (rst) // RL1
        unit_cnt_r <= 23'(LF_UNIT_CYC - 1))
        else $error("low-rate unit counter overran");

    rdata_idle_a: assert property (@(posedge ref_clk) disable iff (rst) // RL5
        !reg_rd |=> reg_rdata == `FPRC_RD_IDLE)
        else $error("read data not idle after a cycle without read");

    span_read_a: assert property (@(posedge ref_clk) disable iff (rst) // RL5
        (reg_rd && reg_addr == `FPRC_OFS_SPAN3) |=> reg_rdata == $past(span_r[2]))
        else $error("remote 2 span register read back wrong");

    ramp_write_a: assert property (@(posedge ref_clk) disable iff (rst) // RL10
        (reg_wr && !lock_r && reg_addr == `FPRC_OFS_RAMP1) |=> ramp_r == $past(reg_wdata))
        else $error("ramp register did not take write");

    lock_drop_a: assert property (@(posedge ref_clk) disable iff (rst) // RL7
        (reg_wr && lock_r) |=> $stable(span_r) && $stable(cfg6_r) && $stable(bhv_r))
        else $error("write landed while locked");

    slot_bound_a: assert property (@(posedge ref_clk) disable iff (rst) // RL10
        slot_cnt_r <= 25'(SLOT1_CYC - 1))
        else $error("ramp slot counter overran");
endmodule

// ===== logic/fprc_cfg.svh
// register map, reset values, field positions and timing for the fan rate/ramp block
`ifndef FPRC_CFG_SVH
`define FPRC_CFG_SVH

`define FPRC_CLK_NS           10
`define FPRC_ADDR_W           8
`define FPRC_DATA_W           8

`define FPRC_OFS_CFG6         8'h10
`define FPRC_OFS_CFG1         8'h40
`define FPRC_OFS_BHV1         8'h5c
`define FPRC_OFS_BHV2         8'h5d
`define FPRC_OFS_BHV3         8'h5e
`define FPRC_OFS_SPAN1        8'h5f
`define FPRC_OFS_SPAN2        8'h60
`define FPRC_OFS_SPAN3        8'h61
`define FPRC_OFS_RAMP1        8'h62

`define FPRC_RST_SPAN         8'hc4
`define FPRC_RST_RAMP         8'h00
`define FPRC_RST_CFG6         8'h00
`define FPRC_RST_CFG1         8'h00
`define FPRC_RST_BHV          3'h3
`define FPRC_RD_IDLE          8'h00

`define FPRC_LOCK_BIT         0
`define FPRC_TBL_BIT          7
`define FPRC_HF_BIT           3
`define FPRC_LOW_RATE_SELECT_MSB         2
`define FPRC_LOW_RATE_SELECT_LSB         0
`define FPRC_SPAN_MSB         7
`define FPRC_SPAN_LSB         4
`define FPRC_RAMP_MSB         2
`define FPRC_RAMP_LSB         0
`define FPRC_SLOW_MSB         2
`define FPRC_SLOW_LSB         0
`define FPRC_BHV_MSB          7
`define FPRC_BHV_LSB          5
`define FPRC_SLOW_LAST        2'h3

// half period of 88.2 Hz, the unit of all low-rate periods
`define FPRC_LF_UNIT_NS       5668934
// ramp time slot for each table, sweep time over 255 duty steps
`define FPRC_SLOT0_US         147058
`define FPRC_SLOT1_US         204705
`define FPRC_NS_PER_US        1000

`endif

// ===== logic/fprc_pkg.sv
// types and decode functions shared by the fan rate/ramp block
package fprc_pkg;
    typedef logic [7:0] fprc_byte_t;

    typedef enum logic [2:0] {
        FPRC_BHV_REMOTE1 = 3'b000,
        FPRC_BHV_LOCAL   = 3'b001,
        FPRC_BHV_REMOTE2 = 3'b010,
        FPRC_BHV_FULL    = 3'b011,
        FPRC_BHV_OFF     = 3'b100,
        FPRC_BHV_LR2     = 3'b101,
        FPRC_BHV_ALL     = 3'b110,
        FPRC_BHV_MANUAL  = 3'b111
    } fprc_channel_behaviour_e;

    // low-rate period in half-periods of 88.2 Hz: 11.0 Hz .. 88.2 Hz
    function automatic logic [4:0] fprc_lf_units(input logic [2:0] code);
        case (code)
            3'h0:    fprc_lf_units = 5'h10;
            3'h1:    fprc_lf_units = 5'h0c;
            3'h2:    fprc_lf_units = 5'h08;
            3'h3:    fprc_lf_units = 5'h06;
            3'h4:    fprc_lf_units = 5'h05;
            3'h5:    fprc_lf_units = 5'h04;
            3'h6:    fprc_lf_units = 5'h03;
            default: fprc_lf_units = 5'h02;
        endcase
    endfunction

    // duty increment per time slot
    function automatic logic [5:0] fprc_ramp_inc(input logic [2:0] code);
        case (code)
            3'h0:    fprc_ramp_inc = 6'h01;
            3'h1:    fprc_ramp_inc = 6'h02;
            3'h2:    fprc_ramp_inc = 6'h03;
            3'h3:    fprc_ramp_inc = 6'h04;
            3'h4:    fprc_ramp_inc = 6'h08;
            3'h5:    fprc_ramp_inc = 6'h0c;
            3'h6:    fprc_ramp_inc = 6'h18;
            default: fprc_ramp_inc = 6'h30;
        endcase
    endfunction
endpackage

// ===== logic/fprc_ramp_if.sv
// link between the register core and the duty ramp stepper
`timescale 1ns/10ps
interface fprc_ramp_if;
    logic             slot_tick;
    logic [5:0]       inc;
    logic [2:0]       slow;
    logic [2:0]       ramp_en;
    logic [2:0][7:0]  target;
    logic [2:0][7:0]  duty;

    modport core  (output slot_tick, inc, slow, ramp_en, target, input duty);
    modport ramp  (input slot_tick, inc, slow, ramp_en, target, output duty);
endinterface

// ===== logic/fprc_ramp.sv
// duty ramp stepper: moves each remote 1 duty toward its target once per slot (every fourth when slow); other duties follow their target
`timescale 1ns/10ps
`include "fprc_cfg.svh"
module fprc_ramp (
    input  wire logic   ref_clk, // system clock
    input  wire logic   rst,     // synchronous reset
    fprc_ramp_if.ramp   rif      // slot, increment and targets in, duty out
);
    logic [2:0][7:0] duty_r;
    logic [2:0][7:0] duty_nxt;
    logic [2:0][1:0] quarter_r;
    logic [2:0][1:0] quarter_nxt;
    logic [8:0]      gap;
    logic            step;

    always_comb begin
        duty_nxt    = duty_r;
        quarter_nxt = quarter_r;
        gap         = 9'h000;
        step        = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (!rif.ramp_en[i]) begin
                duty_nxt[i] = rif.target[i];
            end else if (rif.slot_tick) begin
                // slow ramp: one step every fourth slot
                // RL12 quarter slot rate
                quarter_nxt[i] = quarter_r[i] + 2'h1;
                step = !rif.slow[i] || (quarter_r[i] == `FPRC_SLOW_LAST);
                // RL13 bounded step per slot
                if (step && (rif.target[i] > duty_r[i])) begin
                    gap = {1'b0, rif.target[i]} - {1'b0, duty_r[i]};
                    duty_nxt[i] = (gap > {3'h0, rif.inc}) ? duty_r[i] + {2'h0, rif.inc}
                                                          : rif.target[i];
                end else if (step && (rif.target[i] < duty_r[i])) begin
                    gap = {1'b0, duty_r[i]} - {1'b0, rif.target[i]};
                    duty_nxt[i] = (gap > {3'h0, rif.inc}) ? duty_r[i] - {2'h0, rif.inc}
                                                          : rif.target[i];
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            duty_r    <= '0;
            quarter_r <= '0;
        end else begin
            duty_r    <= duty_nxt;
            quarter_r <= quarter_nxt;
        end
    end

    assign rif.duty = duty_r;

    step_bound_a: assert property (@(posedge ref_clk) disable iff (rst) // RL9
        (rif.ramp_en[0] && $stable(rif.ramp_en[0]) && rif.target[0] > duty_r[0])
        |=> (duty_r[0] - $past(duty_r[0])) <= {2'h0, $past(rif.inc)})
        else $error("remote 1 duty rose by more than the increment");

    idle_hold_a: assert property (@(posedge ref_clk) disable iff (rst) // RL13
        (rif.ramp_en[0] && $past(rif.ramp_en[0]) && !$past(rif.slot_tick))
        |-> $stable(duty_r[0]))
        else $error("ramped duty moved outside a time slot");

    direct_a: assert property (@(posedge ref_clk) disable iff (rst) // RL11
        !rif.ramp_en[1] |=> duty_r[1] == $past(rif.target[1]))
        else $error("unramped duty did not follow its target");
endmodule

// ===== tb/fprc_fan_model.sv
// fan model: counts low-rate drive periods and measures their length in clocks
`timescale 1ns/10ps
module fprc_fan_model (
    input  wire logic        ref_clk,      // system clock
    input  wire logic        rst,          // synchronous reset
    input  wire logic        period_start, // low-rate period start pulse
    output logic      [15:0] pulse_cnt,    // periods seen since reset
    output logic      [15:0] last_period   // clocks in the last full period
);
    logic [15:0] run_cnt;

    always @(posedge ref_clk) begin
        if (rst) begin
            pulse_cnt <= 16'h0000;
            last_period <= 16'h0000;
            run_cnt <= 16'h0000;
        end else if (period_start) begin
            pulse_cnt <= pulse_cnt + 16'h0001;
            last_period <= run_cnt + 16'h0001;
            run_cnt <= 16'h0000;
        end else begin
            run_cnt <= run_cnt + 16'h0001;
        end
    end
endmodule

// ===== tb/tb_fan_pwm_low_rate_select_range_ramp_cfg.sv
// self-checking bench for the fan drive rate, span and ramp configuration block
`timescale 1ns/10ps
`include "fprc_cfg.svh"
module tb_fan_pwm_low_rate_select_range_ramp_cfg;
    localparam int unsigned LF_UNIT = 4;
    localparam int unsigned SLOT0   = 20;
    localparam int unsigned SLOT1   = 28;

    logic        ref_clk;
    logic        rst;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic [23:0] duty_target;
    logic [23:0] duty_now;
    logic [2:0]  drive_type_flag;
    logic [2:0]  lf_period_start;
    logic [11:0] temp_span;
    logic        lock_state;
    logic [15:0] pulse_cnt;
    logic [15:0] last_period;
    logic [15:0] start_cnt;
    logic [15:0] last_period2;
    logic [15:0] pulse_cnt3;
    logic [15:0] start3;
    logic [7:0]  cur;
    int          failures;
    int          check_count;
    int          gap;
    int unsigned per_units [8] = '{16, 12, 8, 6, 5, 4, 3, 2};
    int unsigned inc_tbl   [8] = '{1, 2, 3, 4, 8, 12, 24, 48};

    fprc_top #(.LF_UNIT_CYC(LF_UNIT), .SLOT0_CYC(SLOT0), .SLOT1_CYC(SLOT1)) dut (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .duty_target(duty_target), .duty_now(duty_now),
        .drive_type_flag(drive_type_flag), .lf_period_start(lf_period_start),
        .temp_span(temp_span), .lock_state(lock_state)
    );

    fprc_fan_model fan (
        .ref_clk(ref_clk), .rst(rst), .period_start(lf_period_start[0]),
        .pulse_cnt(pulse_cnt), .last_period(last_period)
    );

    fprc_fan_model fan2 (
        .ref_clk(ref_clk), .rst(rst), .period_start(lf_period_start[1]),
        .pulse_cnt(), .last_period(last_period2)
    );

    fprc_fan_model fan3 (
        .ref_clk(ref_clk), .rst(rst), .period_start(lf_period_start[2]),
        .pulse_cnt(pulse_cnt3), .last_period()
    );

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        check({16'h0000, reg_rdata}, {16'h0000, exp});
    endtask

    // waits for channel one duty to move, returns clocks waited
    task automatic wait_step(output int n);
        logic [7:0] old;
        @(negedge ref_clk);
        old = duty_now[7:0];
        n = 1;
        while (duty_now[7:0] === old && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 400) begin
            failures++;
        end
    endtask

    task automatic wait_pulses(input int k);
        start_cnt = pulse_cnt;
        for (int i = 0; i < 400 && pulse_cnt < start_cnt + k; i++) @(negedge ref_clk);
        if (pulse_cnt < start_cnt + k) begin
            failures++;
        end
    endtask

    task automatic end_of_test();
        if (failures == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial begin
        #200000;
        failures++;
        end_of_test();
    end

    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        duty_target = 24'h000000;
        failures = 0;
        check_count = 0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        check({12'h000, temp_span}, 24'h000ccc);
        check({21'h000000, drive_type_flag}, 24'h000000);
        read_check(`FPRC_OFS_SPAN1, 8'hc4);
        read_check(`FPRC_OFS_SPAN2, 8'hc4);
        read_check(`FPRC_OFS_SPAN3, 8'hc4);
        read_check(`FPRC_OFS_RAMP1, 8'h00);
        read_check(8'h07, 8'h00);
        reg_write(`FPRC_OFS_SPAN1, 8'h0b);
        reg_write(`FPRC_OFS_SPAN2, 8'hf0);
        reg_write(`FPRC_OFS_SPAN3, 8'h58);
        @(negedge ref_clk);
        check({12'h000, temp_span}, 24'h0005f0);
        check({21'h000000, drive_type_flag}, 24'h000005);
        read_check(`FPRC_OFS_SPAN2, 8'hf0);
        read_check(`FPRC_OFS_SPAN3, 8'h58);
        for (int c = 0; c < 8; c++) begin
            reg_write(`FPRC_OFS_SPAN1, {5'h18, c[2:0]});
            wait_pulses(3);
            check({8'h00, last_period}, 24'(per_units[c] * LF_UNIT));
        end
        // rate code ignored in high drive
        reg_write(`FPRC_OFS_SPAN1, 8'hcf);
        repeat (2) @(negedge ref_clk);
        start_cnt = pulse_cnt;
        start3 = pulse_cnt3;
        repeat (200) @(negedge ref_clk);
        check({8'h00, pulse_cnt}, {8'h00, start_cnt});
        check({8'h00, pulse_cnt3}, {8'h00, start3});
        check({8'h00, last_period2}, 24'(per_units[0] * LF_UNIT));
        check({21'h000000, drive_type_flag}, 24'h000005);
        reg_write(`FPRC_OFS_SPAN1, 8'hc7);
        // remote 1 ramp for every increment code
        reg_write(`FPRC_OFS_BHV1, 8'h00);
        cur = 8'h00;
        for (int c = 0; c < 8; c++) begin
            reg_write(`FPRC_OFS_RAMP1, 8'(c));
            duty_target[7:0] <= 8'(cur + inc_tbl[c] + 1);
            wait_step(gap);
            check({16'h0000, duty_now[7:0]}, 24'(cur + inc_tbl[c]));
            wait_step(gap);
            check(24'(gap), 24'(SLOT0));
            check({16'h0000, duty_now[7:0]}, 24'(cur + inc_tbl[c] + 1));
            cur = 8'(cur + inc_tbl[c] + 1);
        end
        // slow bit spaces steps four slots apart
        reg_write(`FPRC_OFS_CFG6, 8'h01);
        reg_write(`FPRC_OFS_RAMP1, 8'h00);
        duty_target[7:0] <= cur + 8'h03;
        wait_step(gap);
        wait_step(gap);
        check(24'(gap), 24'(4 * SLOT0));
        reg_write(`FPRC_OFS_CFG6, 8'h80);
        duty_target[7:0] <= cur + 8'h06;
        wait_step(gap);
        wait_step(gap);
        check(24'(gap), 24'(SLOT1));
        // manual behaviour passes duty straight through
        reg_write(`FPRC_OFS_BHV1, 8'he0);
        duty_target <= 24'h302010;
        repeat (2) @(negedge ref_clk);
        check(duty_now, 24'h302010);
        read_check(`FPRC_OFS_BHV1, 8'he0);
        // lock freezes span and ramp registers
        reg_write(`FPRC_OFS_CFG1, 8'h01);
        @(negedge ref_clk);
        check({23'h000000, lock_state}, 24'h000001);
        reg_write(`FPRC_OFS_SPAN1, 8'h08);
        reg_write(`FPRC_OFS_RAMP1, 8'h05);
        read_check(`FPRC_OFS_SPAN1, 8'hc7);
        read_check(`FPRC_OFS_RAMP1, 8'h00);
        check({21'h000000, drive_type_flag}, 24'h000004);
        check({20'h00000, temp_span[3:0]}, 24'h00000c);
        end_of_test();
    end
endmodule
